// >>> design/bsc_chain.sv
/*
  Boundary-scan chain for port pins, two-wire enables, reset pin,
  oscillators and analog comparator. Test clock and TAP strobes come
  from outside and are sampled by clk; instruction decode is external.
*/
// Behaviour
// - Pin has pull-up cell plus two-stage cell
// - Input data captures raw pin, no synchroniser
// - Normal drive follows port and direction bits
// - Pull-up is not-disable, not-direction, port
// - Alternate functions outside cells; capture sees pin
// - Analog functions scanned at digital-analog boundary
// - Two-wire pins get extra scanned drive enable
// - No scan cell for spike filter
// - Reset pin has two observe-only cells
// - Oscillator enable scanned, clock observe-only
// - Internal RC oscillator not in chain
// - Unused clock reads 0, external RC 1
// - Oscillator enables controllable through chain
// - Load-capacitor fuse not scan-controllable
// - Comparator signals on general scan cells
// - Comparator off, result, mux, bandgap signals
// - Chains shift least significant bit first
// - External test drives latches onto pins
// - Preload loads latches, pins unaffected
`timescale 1ns/1ps
module bsc_chain import bsc_pkg::*; #(
  parameter int NUM_PINS = 8,
  parameter int SCL_PIN = 0,
  parameter int SDA_PIN = 1
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic tck,
  input wire logic tdi,
  input wire logic tapCapture,
  input wire logic tapShift,
  input wire logic tapUpdate,
  input wire logic modeExtest,
  input wire logic modeSample,
  output logic tdo,
  input wire logic [NUM_PINS-1:0] pinPadIn,
  output logic [NUM_PINS-1:0] pinPadOut,
  output logic [NUM_PINS-1:0] pinPadOe,
  output logic [NUM_PINS-1:0] pinPullupOn,
  output logic [NUM_PINS-1:0] pinInputBit,
  input wire logic [NUM_PINS-1:0] pinDirectionBit,
  input wire logic [NUM_PINS-1:0] pinOutputBit,
  input wire logic globalPullupOff,
  input wire logic [TWI_PINS-1:0] twoWireDriveReq,
  output logic [TWI_PINS-1:0] twoWireDriveOn,
  input wire logic normalResetObserve,
  input wire logic highVoltageResetObserve,
  input wire logic [OSC_COUNT-1:0] oscEnableReq,
  input wire logic [OSC_COUNT-1:0] oscClockLine,
  input wire logic [OSC_COUNT-1:0] clockOptionUsed,
  output logic [OSC_COUNT-1:0] oscEnableOut,
  input wire logic internalLoadCapFuse,
  input wire logic crystalNeedsCap,
  input wire logic comparatorPowerOffReq,
  input wire logic comparatorMuxSelectReq,
  input wire logic comparatorBandgapReq,
  input wire logic comparatorResultAnalog,
  output logic comparatorPowerOff,
  output logic comparatorMuxSelect,
  output logic comparatorBandgapOn,
  output logic comparatorResult
);

  if (NUM_PINS < 2 || SCL_PIN == SDA_PIN ||
      SCL_PIN >= NUM_PINS || SDA_PIN >= NUM_PINS) begin : g_badParams
    $error("bsc_chain: bad pin parameters");
  end

  // Outside inputs: three stages, a change counts when the last two agree
  logic [SYNC_LINES-1:0] sync1_reg, sync2_reg, sync3_reg, accepted_reg, acceptedPrev_reg;
  logic tckSeen, tdiSeen, extestOn, chainSelected;
  bsc_strobe_t strobe;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sync1_reg <= SYNC_RESET;
      sync2_reg <= SYNC_RESET;
      sync3_reg <= SYNC_RESET;
    end else begin
      sync1_reg <= {modeSample, modeExtest, tapUpdate, tapShift, tapCapture, tdi, tck};
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      accepted_reg <= SYNC_RESET;
      acceptedPrev_reg <= SYNC_RESET;
    end else begin
      for (int i = 0; i < SYNC_LINES; i++) begin
        if (sync2_reg[i] == sync3_reg[i]) begin
          accepted_reg[i] <= sync3_reg[i];
        end
      end
      acceptedPrev_reg <= accepted_reg;
    end
  end

  assign tckSeen = accepted_reg[0] & ~acceptedPrev_reg[0];
  assign tdiSeen = accepted_reg[1];
  assign extestOn = accepted_reg[5];
  assign chainSelected = accepted_reg[5] | accepted_reg[6];
  // Capture and shift on test clock rise, update on its fall
  assign strobe.capture = chainSelected & accepted_reg[2] & tckSeen;
  assign strobe.shift = chainSelected & accepted_reg[3] & ~accepted_reg[2] & tckSeen;
  assign strobe.update = chainSelected & accepted_reg[4] & ~accepted_reg[0] & acceptedPrev_reg[0];

  // Pin cells nearest the output, then the other cells toward the input
  logic [NUM_PINS-1:0][PIN_CELL_BITS-1:0] pinStages, pinHeld;
  logic [NUM_PINS-1:0] pinShiftIn, pullExpr;
  logic [MISC_CELLS-1:0] miscSo, miscHeld, miscCapture, miscShiftIn;
  logic [OSC_COUNT-1:0] scannedClock;

  always_comb begin
    for (int p = 0; p < NUM_PINS; p++) begin
      pullExpr[p] = ~globalPullupOff & ~pinDirectionBit[p] & pinOutputBit[p];
    end
  end

  genvar p, m;
  generate
    for (p = 0; p < NUM_PINS; p++) begin : g_pin
      if (p == NUM_PINS - 1) begin : g_last
        assign pinShiftIn[p] = miscSo[0];
      end else begin : g_mid
        assign pinShiftIn[p] = pinStages[p+1][PIN_BIT_DATA];
      end
      // Alternate functions join beyond the cell, so the pad is what we see
      bsc_pin_cell u_pin (
        .clk(clk),
        .resetn(resetn),
        .strobe(strobe),
        .shiftIn(pinShiftIn[p]),
        .pullCapture(pullExpr[p]),
        .ctrlCapture(pinDirectionBit[p]),
        .rawPinLevel(pinPadIn[p]),
        .stages(pinStages[p]),
        .held(pinHeld[p])
      );
    end

    for (m = 0; m < MISC_CELLS; m++) begin : g_misc
      if (m == MISC_CELLS - 1) begin : g_last
        assign miscShiftIn[m] = tdiSeen;
      end else begin : g_mid
        assign miscShiftIn[m] = miscSo[m+1];
      end
      bsc_gen_cell #(.OBSERVE_ONLY(bsc_observe_only(m))) u_cell (
        .clk(clk),
        .resetn(resetn),
        .strobe(strobe),
        .shiftIn(miscShiftIn[m]),
        .captureValue(miscCapture[m]),
        .shiftOut(miscSo[m]),
        .heldValue(miscHeld[m])
      );
    end
  endgenerate
  // Internal RC oscillator deliberately has no cell here
  always_comb begin
    for (int k = 0; k < OSC_COUNT; k++) begin
      scannedClock[k] = clockOptionUsed[k] ? oscClockLine[k] : OSC_UNUSED_LEVEL[k];
    end
    miscCapture = '0;
    miscCapture[MISC_TWI_SCL] = twoWireDriveReq[0];
    miscCapture[MISC_TWI_SDA] = twoWireDriveReq[1];
    miscCapture[MISC_RST_NORMAL] = normalResetObserve;
    miscCapture[MISC_RST_HV] = highVoltageResetObserve;
    miscCapture[MISC_OSC_EN +: OSC_COUNT] = oscEnableReq;
    miscCapture[MISC_OSC_CK +: OSC_COUNT] = scannedClock;
    miscCapture[MISC_CMP_OFF] = comparatorPowerOffReq;
    miscCapture[MISC_CMP_RES] = comparatorResultAnalog;
    miscCapture[MISC_CMP_MUX] = comparatorMuxSelectReq;
    miscCapture[MISC_CMP_BG] = comparatorBandgapReq;
  end

  assign tdo = pinStages[0][PIN_BIT_DATA];
  // Pad side: latches reach pins only in external test
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pinPadOut <= '0;
      pinPadOe <= '0;
      pinPullupOn <= '0;
    end else begin
      for (int i = 0; i < NUM_PINS; i++) begin
        if (extestOn) begin
          pinPadOe[i] <= pinHeld[i][PIN_BIT_CTRL];
          pinPadOut[i] <= pinHeld[i][PIN_BIT_DATA];
          pinPullupOn[i] <= pinHeld[i][PIN_BIT_PULL];
        end else begin
          pinPadOe[i] <= pinDirectionBit[i];
          pinPadOut[i] <= pinOutputBit[i];
          pinPullupOn[i] <= pullExpr[i];
        end
      end
    end
  end
  // Core input path keeps its synchroniser; the scan capture does not
  logic [NUM_PINS-1:0] pinSync1_reg, pinSync2_reg, pinSync3_reg;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pinSync1_reg <= '0;
      pinSync2_reg <= '0;
      pinSync3_reg <= '0;
      pinInputBit <= '0;
    end else begin
      pinSync1_reg <= pinPadIn;
      pinSync2_reg <= pinSync1_reg;
      pinSync3_reg <= pinSync2_reg;
      for (int i = 0; i < NUM_PINS; i++) begin
        if (pinSync2_reg[i] == pinSync3_reg[i]) begin
          pinInputBit[i] <= pinSync3_reg[i];
        end
      end
    end
  end
  // Slew-limited driver runs beside the port driver; spike filter unscanned
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      twoWireDriveOn <= '0;
    end else if (extestOn) begin
      twoWireDriveOn <= miscHeld[MISC_TWI_SDA:MISC_TWI_SCL];
    end else begin
      twoWireDriveOn <= twoWireDriveReq;
    end
  end
  // Load-cap fuse gates the crystal but is never taken from the chain
  logic [OSC_COUNT-1:0] oscEnableSel;
  always_comb begin
    oscEnableSel = extestOn ? miscHeld[MISC_OSC_EN +: OSC_COUNT] : oscEnableReq;
    oscEnableSel[1] = oscEnableSel[1] & (~crystalNeedsCap | internalLoadCapFuse);
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      oscEnableOut <= '0;
    end else begin
      oscEnableOut <= oscEnableSel;
    end
  end
  // Comparator cells sit between digital logic and the analog block
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      comparatorPowerOff <= 1'h0;
      comparatorMuxSelect <= 1'h0;
      comparatorBandgapOn <= 1'h0;
      comparatorResult <= 1'h0;
    end else if (extestOn) begin
      comparatorPowerOff <= miscHeld[MISC_CMP_OFF];
      comparatorMuxSelect <= miscHeld[MISC_CMP_MUX];
      comparatorBandgapOn <= miscHeld[MISC_CMP_BG];
      comparatorResult <= miscHeld[MISC_CMP_RES];
    end else begin
      comparatorPowerOff <= comparatorPowerOffReq;
      comparatorMuxSelect <= comparatorMuxSelectReq;
      comparatorBandgapOn <= comparatorBandgapReq;
      comparatorResult <= comparatorResultAnalog;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence s_shiftStep;
    strobe.shift;
  endsequence
  sequence s_updateStep;
    strobe.update ##1 extestOn;
  endsequence

  property p_lsbFirst;
    s_shiftStep |=> tdo == $past(pinStages[0][PIN_BIT_CTRL]);
  endproperty
  a_lsbFirst: assert property (p_lsbFirst) else $error("chain did not shift toward output");
  property p_rawCapture;
    strobe.capture |=> pinStages[0][PIN_BIT_DATA] == $past(pinPadIn[0]);
  endproperty
  a_rawCapture: assert property (p_rawCapture) else $error("input data not raw pad level");
  property p_pullCapture;
    strobe.capture |=> pinStages[0][PIN_BIT_PULL] == $past(pullExpr[0]);
  endproperty
  a_pullCapture: assert property (p_pullCapture) else $error("pull-up capture wrong");
  // Sampled reset skips the release edge, where outputs are still cleared
  property p_normalDrive;
    resetn && !extestOn |=>
      pinPadOe == $past(pinDirectionBit) && pinPadOut == $past(pinOutputBit);
  endproperty
  a_normalDrive: assert property (p_normalDrive) else $error("normal drive not from port");
  property p_pullNormal;
    resetn && !extestOn |=>
      pinPullupOn[0] == $past(~globalPullupOff & ~pinDirectionBit[0] & pinOutputBit[0]);
  endproperty
  a_pullNormal: assert property (p_pullNormal) else $error("pull-up expression wrong");
  property p_extestDrive;
    s_updateStep ##1 extestOn |-> pinPadOe[0] == $past(pinStages[0][PIN_BIT_CTRL], 2);
  endproperty
  a_extestDrive: assert property (p_extestDrive) else $error("update not driven to pin");
  property p_preloadQuiet;
    strobe.update && !extestOn ##1 !extestOn |=> pinPadOut == $past(pinOutputBit);
  endproperty
  a_preloadQuiet: assert property (p_preloadQuiet) else $error("preload disturbed pins");
  property p_unusedRc;
    strobe.capture && !clockOptionUsed[OSC_EXT_RC] |=> miscSo[MISC_OSC_CK + OSC_EXT_RC];
  endproperty
  a_unusedRc: assert property (p_unusedRc) else $error("unused RC clock not 1");
  property p_unusedXtal;
    strobe.capture && !clockOptionUsed[1] |=> !miscSo[MISC_OSC_CK + 1];
  endproperty
  a_unusedXtal: assert property (p_unusedXtal) else $error("unused crystal clock not 0");
  property p_resetObserve;
    strobe.capture |=> miscSo[MISC_RST_HV] == $past(highVoltageResetObserve);
  endproperty
  a_resetObserve: assert property (p_resetObserve) else $error("reset observe wrong");
  property p_twoWire;
    extestOn |=> twoWireDriveOn == $past(miscHeld[MISC_TWI_SDA:MISC_TWI_SCL]);
  endproperty
  a_twoWire: assert property (p_twoWire) else $error("two-wire enable not from chain");
  property p_oscFuse;
    crystalNeedsCap && !internalLoadCapFuse |=> !oscEnableOut[1];
  endproperty
  a_oscFuse: assert property (p_oscFuse) else $error("crystal ran without cap fuse");
  property p_compDrive;
    extestOn |=> comparatorPowerOff == $past(miscHeld[MISC_CMP_OFF]);
  endproperty
  a_compDrive: assert property (p_compDrive) else $error("comparator not chain driven");

endmodule // bsc_chain

// >>> design/bsc_gen_cell.sv
/*
  General or observe-only boundary-scan cell: one shift stage and,
  unless observe-only, one hold latch. Strobes come from the chain top.
*/
`timescale 1ns/1ps
module bsc_gen_cell import bsc_pkg::*; #(
  parameter bit OBSERVE_ONLY = 1'b0
) (
  input wire logic clk,
  input wire logic resetn,
  input wire bsc_strobe_t strobe,
  input wire logic shiftIn,
  input wire logic captureValue,
  output logic shiftOut,
  output logic heldValue
);

  logic stage_reg;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      stage_reg <= CELL_RESET;
    end else if (strobe.capture) begin
      stage_reg <= captureValue;
    end else if (strobe.shift) begin
      stage_reg <= shiftIn;
    end
  end

  assign shiftOut = stage_reg;

  generate
    if (OBSERVE_ONLY) begin : g_obs
      assign heldValue = CELL_RESET;
    end else begin : g_hold
      logic held_reg;
      always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          held_reg <= CELL_RESET;
        end else if (strobe.update) begin
          held_reg <= stage_reg;
        end
      end
      assign heldValue = held_reg;
    end
  endgenerate

endmodule // bsc_gen_cell

// >>> design/bsc_pin_cell.sv
/*
  Bidirectional port pin cell: a pull-up cell plus a two-stage register
  merging output control, output data and raw input data.
*/
`timescale 1ns/1ps
module bsc_pin_cell import bsc_pkg::*; (
  input wire logic clk,
  input wire logic resetn,
  input wire bsc_strobe_t strobe,
  input wire logic shiftIn,
  input wire logic pullCapture,
  input wire logic ctrlCapture,
  input wire logic rawPinLevel,
  output logic [PIN_CELL_BITS-1:0] stages,
  output logic [PIN_CELL_BITS-1:0] held
);

  logic [PIN_CELL_BITS-1:0] stage_reg;
  logic [PIN_CELL_BITS-1:0] held_reg;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      stage_reg <= '0;
    end else if (strobe.capture) begin
      stage_reg[PIN_BIT_PULL] <= pullCapture;
      stage_reg[PIN_BIT_CTRL] <= ctrlCapture;
      stage_reg[PIN_BIT_DATA] <= rawPinLevel;
    end else if (strobe.shift) begin
      stage_reg <= {shiftIn, stage_reg[PIN_CELL_BITS-1:1]};
    end
  end

  // Data stage latch feeds output data; its capture side sees the pin
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      held_reg <= '0;
    end else if (strobe.update) begin
      held_reg <= stage_reg;
    end
  end

  assign stages = stage_reg;
  assign held = held_reg;

endmodule // bsc_pin_cell

// >>> design/bsc_pkg.sv
/*
  Shared constants and carrier types for the boundary-scan cell chain.
  Assumes a single core clock that samples the test clock and strobes.
*/
package bsc_pkg;

  // Bits held by one bidirectional port pin cell: data, control, pull-up
  localparam int PIN_CELL_BITS = 3;
  localparam int PIN_BIT_DATA = 0;
  localparam int PIN_BIT_CTRL = 1;
  localparam int PIN_BIT_PULL = 2;

  // Positions of the non-pin cells, counted from the end nearest the output
  localparam int MISC_CELLS = 18;
  localparam int MISC_TWI_SCL = 0;
  localparam int MISC_TWI_SDA = 1;
  localparam int MISC_RST_NORMAL = 2;
  localparam int MISC_RST_HV = 3;
  localparam int MISC_OSC_EN = 4;
  localparam int MISC_OSC_CK = 9;
  localparam int MISC_CMP_OFF = 14;
  localparam int MISC_CMP_RES = 15;
  localparam int MISC_CMP_MUX = 16;
  localparam int MISC_CMP_BG = 17;

  // Clock options: external clock, crystal, external RC, low-freq crystal, timer
  localparam int OSC_COUNT = 5;
  localparam int OSC_EXT_RC = 2;
  localparam logic [4:0] OSC_UNUSED_LEVEL = 5'h04;

  localparam int TWI_PINS = 2;
  localparam int SYNC_DEPTH = 3;
  localparam int SYNC_LINES = 7;
  localparam logic [6:0] SYNC_RESET = 7'h00;
  localparam logic CELL_RESET = 1'h0;

  // Test access strobes, each valid for one core clock
  typedef struct packed {
    logic capture;
    logic shift;
    logic update;
  } bsc_strobe_t;

  // Observe-only cells have no hold latch
  function automatic bit bsc_observe_only(input int idx);
    return (idx == MISC_RST_NORMAL) || (idx == MISC_RST_HV) ||
           ((idx >= MISC_OSC_CK) && (idx < MISC_OSC_CK + OSC_COUNT));
  endfunction

endpackage

// >>> verif/bsc_chain_tb_top.sv
/*
  Self-checking bench for the boundary-scan chain, with a reference
  model of capture and drive. Assumes the tester model drives the TAP.
*/
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_fail++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, a, b); end end
module bsc_chain_tb_top import bsc_pkg::*;;
  localparam int NP = 8;
  localparam int M = 3 * NP;
  localparam int L = M + MISC_CELLS;
  logic clk = 1'b0;
  logic resetn, tck, tdi, tapCapture, tapShift, tapUpdate, modeExtest, modeSample, tdo;
  logic [NP-1:0] pinPadIn, pinPadOut, pinPadOe, pinPullupOn, pinInputBit;
  logic [NP-1:0] pinDirectionBit, pinOutputBit;
  logic globalPullupOff, normalResetObserve, highVoltageResetObserve;
  logic [TWI_PINS-1:0] twoWireDriveReq, twoWireDriveOn;
  logic [OSC_COUNT-1:0] oscEnableReq, oscClockLine, clockOptionUsed, oscEnableOut;
  logic internalLoadCapFuse, crystalNeedsCap, comparatorResultAnalog;
  logic comparatorPowerOffReq, comparatorMuxSelectReq, comparatorBandgapReq;
  logic comparatorPowerOff, comparatorMuxSelect, comparatorBandgapOn, comparatorResult;
  logic [31:0] seed = 32'hc5bb;
  logic [63:0] w;
  logic [L-1:0] din, got, ld, ex, mask, prev;
  int n_fail = 0;
  int cmp_count = 0;

  always #5 clk = ~clk;

  bsc_tester_model #(.NUM_PINS(NP)) tester (.tck(tck), .tdi(tdi), .tapCapture(tapCapture),
    .tapShift(tapShift), .tapUpdate(tapUpdate), .tdo(tdo));

  bsc_chain #(.NUM_PINS(NP), .SCL_PIN(0), .SDA_PIN(1)) DUT (.clk(clk), .resetn(resetn),
    .tck(tck), .tdi(tdi), .tapCapture(tapCapture), .tapShift(tapShift),
    .tapUpdate(tapUpdate), .modeExtest(modeExtest), .modeSample(modeSample), .tdo(tdo),
    .pinPadIn(pinPadIn), .pinPadOut(pinPadOut), .pinPadOe(pinPadOe),
    .pinPullupOn(pinPullupOn), .pinInputBit(pinInputBit),
    .pinDirectionBit(pinDirectionBit), .pinOutputBit(pinOutputBit),
    .globalPullupOff(globalPullupOff), .twoWireDriveReq(twoWireDriveReq),
    .twoWireDriveOn(twoWireDriveOn), .normalResetObserve(normalResetObserve),
    .highVoltageResetObserve(highVoltageResetObserve), .oscEnableReq(oscEnableReq),
    .oscClockLine(oscClockLine), .clockOptionUsed(clockOptionUsed),
    .oscEnableOut(oscEnableOut), .internalLoadCapFuse(internalLoadCapFuse),
    .crystalNeedsCap(crystalNeedsCap), .comparatorPowerOffReq(comparatorPowerOffReq),
    .comparatorMuxSelectReq(comparatorMuxSelectReq),
    .comparatorBandgapReq(comparatorBandgapReq),
    .comparatorResultAnalog(comparatorResultAnalog),
    .comparatorPowerOff(comparatorPowerOff), .comparatorMuxSelect(comparatorMuxSelect),
    .comparatorBandgapOn(comparatorBandgapOn), .comparatorResult(comparatorResult));

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Crystal runs only if it needs no load cap or its load-cap fuse is set
  function automatic logic [4:0] gate(input logic [4:0] e);
    gate = e;
    gate[1] = e[1] & (~crystalNeedsCap | internalLoadCapFuse);
  endfunction

  function automatic logic [L-1:0] exp_cap();
    logic [L-1:0] e;
    for (int i = 0; i < NP; i++) begin
      e[3*i+PIN_BIT_DATA] = pinPadIn[i];
      e[3*i+PIN_BIT_CTRL] = pinDirectionBit[i];
      e[3*i+PIN_BIT_PULL] = ~globalPullupOff & ~pinDirectionBit[i] & pinOutputBit[i];
    end
    e[M+MISC_TWI_SCL +: 2] = twoWireDriveReq;
    e[M+MISC_RST_NORMAL] = normalResetObserve;
    e[M+MISC_RST_HV] = highVoltageResetObserve;
    e[M+MISC_OSC_EN +: 5] = oscEnableReq;
    for (int k = 0; k < OSC_COUNT; k++) begin
      e[M+MISC_OSC_CK+k] = clockOptionUsed[k] ? oscClockLine[k] : (k == 2);
    end
    e[M+MISC_CMP_OFF] = comparatorPowerOffReq;
    e[M+MISC_CMP_RES] = comparatorResultAnalog;
    e[M+MISC_CMP_MUX] = comparatorMuxSelectReq;
    e[M+MISC_CMP_BG] = comparatorBandgapReq;
    return e;
  endfunction

  task automatic drive_random();
    logic [31:0] r;
    logic [31:0] q;
    r = xs();
    q = xs();
    @(posedge clk);
    pinPadIn <= r[7:0];
    pinDirectionBit <= r[15:8];
    pinOutputBit <= r[23:16];
    globalPullupOff <= r[24];
    twoWireDriveReq <= r[26:25];
    normalResetObserve <= r[27];
    highVoltageResetObserve <= r[28];
    internalLoadCapFuse <= r[29];
    crystalNeedsCap <= r[30];
    comparatorResultAnalog <= r[31];
    oscEnableReq <= q[4:0];
    oscClockLine <= q[9:5];
    clockOptionUsed <= q[14:10];
    comparatorPowerOffReq <= q[15];
    comparatorMuxSelectReq <= q[16];
    comparatorBandgapReq <= q[17];
    repeat (8) @(posedge clk);
  endtask

  task automatic chk_core();
    `CHK(pinPadOut, pinOutputBit);
    `CHK(pinPadOe, pinDirectionBit);
    `CHK(pinPullupOn, ~{NP{globalPullupOff}} & ~pinDirectionBit & pinOutputBit);
    `CHK(pinInputBit, pinPadIn);
    `CHK(twoWireDriveOn, twoWireDriveReq);
    `CHK(oscEnableOut, gate(oscEnableReq));
    `CHK({comparatorPowerOff, comparatorMuxSelect, comparatorBandgapOn, comparatorResult},
      {comparatorPowerOffReq, comparatorMuxSelectReq, comparatorBandgapReq,
       comparatorResultAnalog});
  endtask

  task automatic chk_latch(input logic [L-1:0] d);
    logic [NP-1:0] po;
    logic [NP-1:0] oe;
    logic [NP-1:0] pu;
    for (int i = 0; i < NP; i++) begin
      po[i] = d[3*i+PIN_BIT_DATA];
      oe[i] = d[3*i+PIN_BIT_CTRL];
      pu[i] = d[3*i+PIN_BIT_PULL];
    end
    `CHK({pinPadOut, pinPadOe, pinPullupOn}, {po, oe, pu});
    `CHK(twoWireDriveOn, d[M+MISC_TWI_SCL +: 2]);
    `CHK(oscEnableOut, gate(d[M+MISC_OSC_EN +: 5]));
    `CHK({comparatorBandgapOn, comparatorMuxSelect, comparatorResult, comparatorPowerOff},
      d[M+MISC_CMP_OFF +: 4]);
  endtask

  task automatic do_scan();
    drive_random();
    ex = exp_cap();
    w = {xs(), xs()};
    din = w[L-1:0];
    tester.scan(din, got, ld);
    repeat (4) @(posedge clk);
  endtask

  task automatic end_sim();
    $display("counts: compares=%0d mismatches=%0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic do_reset();
    @(posedge clk);
    resetn <= 1'b0;
    repeat (8) @(posedge clk);
    `CHK({pinPadOe, pinPadOut, twoWireDriveOn, oscEnableOut, tdo}, '0);
    resetn <= 1'b1;
    repeat (10) @(posedge clk);
  endtask

  initial begin
    repeat (100000) @(posedge clk);
    n_fail++;
    end_sim();
  end

  initial begin
    {resetn, modeExtest, modeSample, pinPadIn, pinDirectionBit, pinOutputBit} = '0;
    {globalPullupOff, twoWireDriveReq, normalResetObserve, highVoltageResetObserve} = '0;
    {oscEnableReq, oscClockLine, clockOptionUsed, internalLoadCapFuse, crystalNeedsCap} = '0;
    {comparatorPowerOffReq, comparatorMuxSelectReq, comparatorBandgapReq} = '0;
    comparatorResultAnalog = 1'b0;
    for (int i = 0; i < M; i += 3) mask[i+:3] = 3'h1;
    mask[L-1:M] = 18'h03e0c;
    do_reset();
    for (int n = 0; n < 6; n++) begin
      drive_random();
      chk_core();
    end
    $display("test core_follow done");
    modeSample <= 1'b1;
    for (int n = 0; n < 3; n++) begin
      if (n == 2) tester.half = 100.0;
      do_scan();
      `CHK(got, ex);
      chk_core();
    end
    tester.half = 62.5;
    $display("test sample_preload done");
    modeSample <= 1'b0;
    modeExtest <= 1'b1;
    repeat (8) @(posedge clk);
    chk_latch(ld);
    do_scan();
    `CHK(got & mask, ex & mask);
    chk_latch(ld);
    $display("test extest done");
    modeExtest <= 1'b0;
    prev = ld;
    do_scan();
    `CHK(got, {L{prev[0]}});
    chk_core();
    modeExtest <= 1'b1;
    repeat (8) @(posedge clk);
    chk_latch(prev);
    $display("test refused_strobes done");
    modeExtest <= 1'b0;
    do_reset();
    drive_random();
    chk_core();
    $display("test second_reset done");
    end_sim();
  end
endmodule // bsc_chain_tb_top

// >>> verif/bsc_tester_model.sv
/*
  Tester model: drives test clock, serial data and TAP state levels for
  one data-register scan of the boundary-scan chain.
  Assumes the bench sets the instruction mode bits around each scan.
*/
`timescale 1ns/1ps
module bsc_tester_model import bsc_pkg::*; #(
  parameter int NUM_PINS = 8
) (
  output logic tck,
  output logic tdi,
  output logic tapCapture,
  output logic tapShift,
  output logic tapUpdate,
  input wire logic tdo
);
  localparam int L = 3 * NUM_PINS + MISC_CELLS;
  localparam int M = 3 * NUM_PINS;
  // Half period; raise it for a slow tester
  realtime half = 62.5;

  initial begin
    tck = 1'b0;
    tdi = 1'b0;
    tapCapture = 1'b0;
    tapShift = 1'b0;
    tapUpdate = 1'b0;
  end

  // Test clock stands low between frames
  task automatic scan(input logic [L-1:0] din, output logic [L-1:0] dout,
                      output logic [L-1:0] loaded);
    logic found;
    loaded = din;
    found = 1'b0;
    for (int p = 0; p < TWI_PINS; p++) begin
      if (loaded[3*p+PIN_BIT_CTRL]) loaded[M+MISC_TWI_SCL+p] = 1'b0;
    end
    for (int k = 0; k < OSC_COUNT; k++) begin
      if (found) loaded[M+MISC_OSC_EN+k] = 1'b0;
      found = found | loaded[M+MISC_OSC_EN+k];
    end
    #1 tapCapture = 1'b1;  // Off the core clock edge, so no sampling race
    #half tck = 1'b1;
    #half tck = 1'b0;
    tapCapture = 1'b0;
    tapShift = 1'b1;
    for (int i = 0; i < L; i++) begin
      tdi = loaded[i];
      #half dout[i] = tdo;
      tck = 1'b1;
      #half tck = 1'b0;
    end
    tapShift = 1'b0;
    tapUpdate = 1'b1;
    #half tck = 1'b1;
    #half tck = 1'b0;
    // Held past the fall: the fall is seen four core clocks late by the filter
    #half tapUpdate = 1'b0;
    tdi = ~tdi;
  endtask
endmodule // bsc_tester_model
